// ==== logic/srcfg_top.sv ====
// Strap capture, switch mode decode and global reset and halt control.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Frequency select 0 means a 100 MHz reference and 1 means 125 MHz.
// - Each merge strap is active low and an undriven one reads as low, selecting merge.
// - A low merge strap joins a pair into one x8 port with the odd lanes as lanes 4 to 7.
// - A high merge strap keeps both ports of the pair apart as independent x4 ports.
// - While global reset is asserted all internal logic is held in reset.
// - With reset halt set the reset sequence runs and reset then holds with SMBus ports on.
// - In the halt state register reads and writes are accepted.
// - Normal operation starts only when an SMBus master clears the halt bit.
// - Mode 0 is one partition and mode 1 one partition with EEPROM initialization.
// - Modes 8 and A: port 0 up, port 2 off; 9 and B: the reverse; A and B add EEPROM.
// - Mode C is multi-partition and mode D multi-partition with EEPROM initialization.
module srcfg_top #(
    parameter int NUM_PAIRS = srcfg_pkg::NUM_PAIRS
) (
    input  wire logic                             MCLK,
    input  wire logic                             RST_N,
    input  wire logic                             GLOBAL_RESET_N,
    input  wire logic                             RESET_HALT,
    input  wire logic [srcfg_pkg::FSEL_W-1:0]     REFCLK_FREQ_SELECT,
    input  wire logic [NUM_PAIRS-1:0]             PAIR_MERGE_N,
    input  wire logic [srcfg_pkg::MODE_W-1:0]     SWITCH_MODE_STRAP,
    input  wire logic                             HALT_BIT_CLEAR,
    input  wire logic                             REG_ACCESS_REQ,
    output logic                                  CORE_RESET_N,
    output logic                                  SMBUS_ENABLE,
    output logic                                  REG_ACCESS_ALLOW,
    output logic                                  HALT_BIT,
    output logic                                  REFCLK_125MHZ,
    output logic [NUM_PAIRS-1:0]                  PAIR_MERGED,
    output logic [2*NUM_PAIRS-1:0]                PORT_ENABLE,
    output logic [2*NUM_PAIRS*4-1:0]              PORT_LANE_COUNT,
    output logic [2*NUM_PAIRS-1:0]                PORT_HIGH_LANES_TO_EVEN,
    output logic                                  EEPROM_INIT,
    output logic                                  MULTI_PARTITION,
    output logic [srcfg_pkg::UPSTREAM_W-1:0]      UPSTREAM_PORT,
    output logic                                  MODE_RESERVED
);
    typedef struct packed {
        srcfg_pkg::srcfg_state_t                st;
        logic [srcfg_pkg::RESET_CYCLES_W-1:0]   cnt;
        logic                                   halt_req;
        logic                                   halt_bit;
        logic [srcfg_pkg::FSEL_W-1:0]           fsel;
        logic [NUM_PAIRS-1:0]                   merge_n;
        logic [srcfg_pkg::MODE_W-1:0]           mode;
        logic                                   core_rst_n;
        logic                                   smb_en;
        logic                                   reg_allow;
        logic                                   clk125;
        logic [NUM_PAIRS-1:0]                   merged;
        logic [2*NUM_PAIRS-1:0]                 port_en;
        logic [2*NUM_PAIRS*4-1:0]               lanes;
        logic [2*NUM_PAIRS-1:0]                 hi_map;
        logic                                   ee;
        logic                                   multi;
        logic [srcfg_pkg::UPSTREAM_W-1:0]       up;
        logic                                   rsvd;
    } srcfg_regs_t;

    srcfg_regs_t r;
    srcfg_regs_t next_r;

    logic                                 dec_ee;
    logic                                 dec_multi;
    logic                                 dec_rsvd;
    logic [srcfg_pkg::UPSTREAM_W-1:0]     dec_up;
    logic [2*NUM_PAIRS-1:0]               dec_en;
    logic [2*NUM_PAIRS*4-1:0]             dec_lanes;
    logic [2*NUM_PAIRS-1:0]               dec_hi;

    // Mode decode from the held strap copy.
    always_comb begin
        dec_ee    = 1'b0;
        dec_multi = 1'b0;
        dec_rsvd  = 1'b0;
        dec_up    = srcfg_pkg::UP_NONE;
        dec_en    = '1;
        unique case (r.mode)
            srcfg_pkg::MODE_SINGLE: begin
                dec_ee = 1'b0;
            end
            srcfg_pkg::MODE_SINGLE_EE: begin
                dec_ee = 1'b1;
            end
            srcfg_pkg::MODE_UP0, srcfg_pkg::MODE_UP0_EE: begin
                dec_up    = srcfg_pkg::UP_P0;
                dec_en[2] = 1'b0;
                dec_ee    = (r.mode == srcfg_pkg::MODE_UP0_EE);
            end
            srcfg_pkg::MODE_UP2, srcfg_pkg::MODE_UP2_EE: begin
                dec_up    = srcfg_pkg::UP_P2;
                dec_en[0] = 1'b0;
                dec_ee    = (r.mode == srcfg_pkg::MODE_UP2_EE);
            end
            srcfg_pkg::MODE_MULTI: begin
                dec_multi = 1'b1;
            end
            srcfg_pkg::MODE_MULTI_EE: begin
                dec_multi = 1'b1;
                dec_ee    = 1'b1;
            end
            default: begin
                dec_rsvd = 1'b1;
            end
        endcase
    end

    // Per pair port width and lane mapping.
    for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
        always_comb begin
            if (!r.merge_n[p]) begin
                dec_lanes[(2*p)*4 +: 4]   = 4'(2*srcfg_pkg::LANES_X4);
                dec_lanes[(2*p+1)*4 +: 4] = 4'h0;
                dec_hi[2*p]               = 1'b0;
                dec_hi[2*p+1]             = 1'b1;
            end else begin
                dec_lanes[(2*p)*4 +: 4]   = 4'(srcfg_pkg::LANES_X4);
                dec_lanes[(2*p+1)*4 +: 4] = 4'(srcfg_pkg::LANES_X4);
                dec_hi[2*p]               = 1'b0;
                dec_hi[2*p+1]             = 1'b0;
            end
        end
    end

    always_comb begin
        next_r = r;
        unique case (r.st)
            srcfg_pkg::SRCFG_RESET: begin
                next_r.core_rst_n = 1'b0;
                next_r.smb_en     = 1'b0;
                next_r.reg_allow  = 1'b0;
                next_r.halt_req   = r.halt_req | RESET_HALT;
                if (GLOBAL_RESET_N) begin
                    next_r.fsel    = REFCLK_FREQ_SELECT;
                    next_r.merge_n = PAIR_MERGE_N;
                    next_r.mode    = SWITCH_MODE_STRAP;
                    next_r.cnt     = srcfg_pkg::RESET_SEQ_CYCLES;
                    next_r.st      = srcfg_pkg::SRCFG_SEQ;
                end
            end
            srcfg_pkg::SRCFG_SEQ: begin
                next_r.cnt = r.cnt - 1'b1;
                if (r.cnt == 1'b1) begin
                    if (r.halt_req) begin
                        next_r.halt_bit  = 1'b1;
                        next_r.smb_en    = 1'b1;
                        next_r.reg_allow = 1'b1;
                        next_r.st        = srcfg_pkg::SRCFG_HALT;
                    end else begin
                        next_r.core_rst_n = 1'b1;
                        next_r.smb_en     = 1'b1;
                        next_r.reg_allow  = 1'b1;
                        next_r.st         = srcfg_pkg::SRCFG_RUN;
                    end
                end
            end
            srcfg_pkg::SRCFG_HALT: begin
                if (HALT_BIT_CLEAR) begin
                    next_r.halt_bit   = 1'b0;
                    next_r.core_rst_n = 1'b1;
                    next_r.st         = srcfg_pkg::SRCFG_RUN;
                end
            end
            srcfg_pkg::SRCFG_RUN: begin
                next_r.core_rst_n = 1'b1;
            end
            default: begin
                next_r.st = srcfg_pkg::SRCFG_RESET;
            end
        endcase
        next_r.clk125  = (r.fsel == srcfg_pkg::FSEL_125MHZ);
        next_r.merged  = ~r.merge_n;
        next_r.port_en = dec_en;
        next_r.lanes   = dec_lanes;
        next_r.hi_map  = dec_hi;
        next_r.ee      = dec_ee;
        next_r.multi   = dec_multi;
        next_r.up      = dec_up;
        next_r.rsvd    = dec_rsvd;
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N || !GLOBAL_RESET_N) begin
            r            <= '0;
            r.st         <= srcfg_pkg::SRCFG_RESET;
            r.merge_n    <= '1;
            r.port_en    <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign CORE_RESET_N            = r.core_rst_n;
    assign SMBUS_ENABLE            = r.smb_en;
    assign REG_ACCESS_ALLOW        = r.reg_allow;
    assign HALT_BIT                = r.halt_bit;
    assign REFCLK_125MHZ           = r.clk125;
    assign PAIR_MERGED             = r.merged;
    assign PORT_ENABLE             = r.port_en;
    assign PORT_LANE_COUNT         = r.lanes;
    assign PORT_HIGH_LANES_TO_EVEN = r.hi_map;
    assign EEPROM_INIT             = r.ee;
    assign MULTI_PARTITION         = r.multi;
    assign UPSTREAM_PORT           = r.up;
    assign MODE_RESERVED           = r.rsvd;

    core_held_a: assert property (
        @(posedge MCLK) disable iff (!RST_N)
        !GLOBAL_RESET_N |=> !CORE_RESET_N)
        else $error("core left reset during global reset");
    seq_held_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st == srcfg_pkg::SRCFG_SEQ |-> !CORE_RESET_N && !HALT_BIT && !SMBUS_ENABLE)
        else $error("core, halt bit or SMBus active during the reset sequence");
    halt_holds_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        (r.st == srcfg_pkg::SRCFG_HALT && !HALT_BIT_CLEAR) |=> !CORE_RESET_N && SMBUS_ENABLE)
        else $error("halt state did not hold reset with SMBus on");
    halt_smbus_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        HALT_BIT |-> SMBUS_ENABLE && !CORE_RESET_N)
        else $error("halt bit set without SMBus or with the core running");
    halt_regs_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        HALT_BIT |-> REG_ACCESS_ALLOW)
        else $error("registers closed while halted");
    halt_access_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        HALT_BIT && REG_ACCESS_REQ |-> REG_ACCESS_ALLOW && SMBUS_ENABLE)
        else $error("register access refused while halted");
    halt_release_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        (HALT_BIT && HALT_BIT_CLEAR) |=> CORE_RESET_N && !HALT_BIT)
        else $error("clearing the halt bit did not release the core");
    run_needs_clear_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        $rose(CORE_RESET_N) && $past(r.halt_req) |-> $past(HALT_BIT_CLEAR))
        else $error("core released from halt without clear");
    straps_held_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st != srcfg_pkg::SRCFG_RESET |=> $stable(r.mode) && $stable(r.merge_n)
        && $stable(r.fsel))
        else $error("captured straps changed");
    freq_decode_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st == srcfg_pkg::SRCFG_RUN |-> REFCLK_125MHZ == (r.fsel == srcfg_pkg::FSEL_125MHZ))
        else $error("reference frequency decode wrong");
    merge_lanes_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st == srcfg_pkg::SRCFG_RUN && !r.merge_n[0] |-> PAIR_MERGED[0]
        && PORT_HIGH_LANES_TO_EVEN[1] && PORT_LANE_COUNT[3:0] == 4'h8)
        else $error("merged pair not x8");
    split_lanes_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st == srcfg_pkg::SRCFG_RUN && r.merge_n[0] |-> !PAIR_MERGED[0]
        && PORT_LANE_COUNT[7:4] == 4'h4)
        else $error("split pair not x4");
    for (genvar q = 0; q < NUM_PAIRS; q++) begin : g_pair_chk
        pair_total_a: assert property (
            @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
            r.st == srcfg_pkg::SRCFG_RUN |-> 4'(PORT_LANE_COUNT[(2*q)*4 +: 4]
            + PORT_LANE_COUNT[(2*q+1)*4 +: 4]) == 4'(2*srcfg_pkg::LANES_X4))
            else $error("pair does not carry eight lanes");
        pair_map_a: assert property (
            @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
            r.st == srcfg_pkg::SRCFG_RUN |-> PAIR_MERGED[q] == PORT_HIGH_LANES_TO_EVEN[2*q+1]
            && PAIR_MERGED[q] == !r.merge_n[q])
            else $error("pair merge flag and lane map disagree");
    end
    single_plain_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st == srcfg_pkg::SRCFG_RUN && r.mode == srcfg_pkg::MODE_SINGLE |-> !EEPROM_INIT
        && !MULTI_PARTITION && UPSTREAM_PORT == srcfg_pkg::UP_NONE)
        else $error("mode 0 decode wrong");
    single_mode_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st == srcfg_pkg::SRCFG_RUN && r.mode == srcfg_pkg::MODE_SINGLE_EE |-> EEPROM_INIT
        && !MULTI_PARTITION)
        else $error("mode 1 decode wrong");
    up0_port_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st == srcfg_pkg::SRCFG_RUN && r.mode == srcfg_pkg::MODE_UP0 |-> !PORT_ENABLE[2]
        && PORT_ENABLE[0] && !EEPROM_INIT && UPSTREAM_PORT == srcfg_pkg::UP_P0)
        else $error("mode 8 decode wrong");
    up2_port_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st == srcfg_pkg::SRCFG_RUN && r.mode == srcfg_pkg::MODE_UP2 |-> !PORT_ENABLE[0]
        && PORT_ENABLE[2] && !EEPROM_INIT && UPSTREAM_PORT == srcfg_pkg::UP_P2)
        else $error("mode 9 decode wrong");
    up0_eeprom_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st == srcfg_pkg::SRCFG_RUN && r.mode == srcfg_pkg::MODE_UP0_EE |-> !PORT_ENABLE[2]
        && EEPROM_INIT && UPSTREAM_PORT == srcfg_pkg::UP_P0)
        else $error("mode A decode wrong");
    up_port_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st == srcfg_pkg::SRCFG_RUN && r.mode == srcfg_pkg::MODE_UP2_EE |-> !PORT_ENABLE[0]
        && EEPROM_INIT && UPSTREAM_PORT == srcfg_pkg::UP_P2)
        else $error("mode B decode wrong");
    multi_plain_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st == srcfg_pkg::SRCFG_RUN && r.mode == srcfg_pkg::MODE_MULTI |-> MULTI_PARTITION
        && !EEPROM_INIT && UPSTREAM_PORT == srcfg_pkg::UP_NONE)
        else $error("mode C decode wrong");
    multi_mode_a: assert property (
        @(posedge MCLK) disable iff (!RST_N || !GLOBAL_RESET_N)
        r.st == srcfg_pkg::SRCFG_RUN && r.mode == srcfg_pkg::MODE_MULTI_EE |-> MULTI_PARTITION
        && EEPROM_INIT)
        else $error("mode D decode wrong");
endmodule
`default_nettype wire

// ==== shared/srcfg_pkg.sv ====
// Package with strap encodings, state codes and the reset sequence length of the strap and reset block.
`default_nettype none
package srcfg_pkg;
    localparam int NUM_PAIRS = 4;
    localparam int MODE_W    = 4;
    localparam int FSEL_W    = 1;
    localparam int LANES_X4  = 4;

    localparam logic [FSEL_W-1:0] FSEL_100MHZ = 1'h0;
    localparam logic [FSEL_W-1:0] FSEL_125MHZ = 1'h1;

    localparam logic [MODE_W-1:0] MODE_SINGLE         = 4'h0;
    localparam logic [MODE_W-1:0] MODE_SINGLE_EE      = 4'h1;
    localparam logic [MODE_W-1:0] MODE_UP0            = 4'h8;
    localparam logic [MODE_W-1:0] MODE_UP2            = 4'h9;
    localparam logic [MODE_W-1:0] MODE_UP0_EE         = 4'hA;
    localparam logic [MODE_W-1:0] MODE_UP2_EE         = 4'hB;
    localparam logic [MODE_W-1:0] MODE_MULTI          = 4'hC;
    localparam logic [MODE_W-1:0] MODE_MULTI_EE       = 4'hD;

    localparam int UPSTREAM_W = 2;
    localparam logic [UPSTREAM_W-1:0] UP_NONE = 2'h0;
    localparam logic [UPSTREAM_W-1:0] UP_P0   = 2'h1;
    localparam logic [UPSTREAM_W-1:0] UP_P2   = 2'h2;

    localparam int RESET_CYCLES_W = 4;
    localparam logic [RESET_CYCLES_W-1:0] RESET_SEQ_CYCLES = 4'h8;

    typedef enum logic [3:0] {
        SRCFG_RESET = 4'h1,
        SRCFG_SEQ   = 4'h2,
        SRCFG_HALT  = 4'h4,
        SRCFG_RUN   = 4'h8
    } srcfg_state_t;
endpackage
`default_nettype wire

// ==== tb/srcfg_board.sv ====
// Board model that drives the straps, the global reset pin and the halt bit clear.
`timescale 1ns/10ps
`default_nettype none
module srcfg_board (
    input  wire logic       mclk,
    input  wire logic       release_req,
    input  wire logic       clear_req,
    input  wire logic       halt,
    input  wire logic       fsel,
    input  wire logic [3:0] merge_n,
    input  wire logic [3:0] undriven,
    input  wire logic [3:0] mode,
    output logic            global_reset_n,
    output logic            reset_halt,
    output logic            halt_clear,
    output logic            fsel_pin,
    output logic [3:0]      merge_pin,
    output logic [3:0]      mode_pin
);
    initial begin
        {global_reset_n, reset_halt, halt_clear, fsel_pin} = 4'h0;
        merge_pin = 4'hF;
        mode_pin = 4'h0;
    end
    always @(negedge mclk) begin
        global_reset_n <= release_req;
        reset_halt <= halt;
        halt_clear <= clear_req;
        if (!release_req) begin
            fsel_pin <= fsel;
            merge_pin <= merge_n & ~undriven;
            mode_pin <= (mode inside {[4'h2:4'h7], 4'hE, 4'hF}) ? 4'h0 : mode;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the strap and reset block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [3:0] mode;
        logic [3:0] merge_n;
        logic       fsel;
        logic       halt;
        logic       eep;
        logic       multi;
        logic [1:0] up;
        logic [1:0] en;
    } srcfg_row_t;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        rel = 1'b0;
    logic        clr = 1'b0;
    logic [3:0]  undriven = 4'h0;
    srcfg_row_t  cur = '0;
    logic        gr_n, rh, hc, fsel_pin, core_reset_n, smbus_en, reg_allow, halt_bit;
    logic        refclk125, eeprom, multi, reserved;
    logic [3:0]  merge_pin, mode_pin, merged;
    logic [7:0]  port_en, high;
    logic [31:0] lanes_out;
    logic [1:0]  upstream;
    int          fail_count = 0;
    int          checks = 0;
    srcfg_row_t  rows [8] = '{
        '{4'h0, 4'hF, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 2'h3},
        '{4'h1, 4'h0, 1'h1, 1'h1, 1'h1, 1'h0, 2'h0, 2'h3},
        '{4'h8, 4'h5, 1'h0, 1'h0, 1'h0, 1'h0, 2'h1, 2'h1},
        '{4'h9, 4'hA, 1'h1, 1'h0, 1'h0, 1'h0, 2'h2, 2'h2},
        '{4'hA, 4'h3, 1'h0, 1'h1, 1'h1, 1'h0, 2'h1, 2'h1},
        '{4'hB, 4'hC, 1'h1, 1'h1, 1'h1, 1'h0, 2'h2, 2'h2},
        '{4'hC, 4'h0, 1'h0, 1'h0, 1'h0, 1'h1, 2'h0, 2'h3},
        '{4'hD, 4'hF, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0, 2'h3}};
    always #2.5 mclk = ~mclk;
    srcfg_board srcfg_board_i (.mclk(mclk), .release_req(rel), .clear_req(clr),
        .halt(cur.halt), .fsel(cur.fsel), .merge_n(cur.merge_n), .undriven(undriven),
        .mode(cur.mode), .global_reset_n(gr_n), .reset_halt(rh), .halt_clear(hc),
        .fsel_pin(fsel_pin), .merge_pin(merge_pin), .mode_pin(mode_pin));
    srcfg_top srcfg_top_i (.MCLK(mclk), .RST_N(rst_n), .GLOBAL_RESET_N(gr_n),
        .RESET_HALT(rh), .REFCLK_FREQ_SELECT(fsel_pin), .PAIR_MERGE_N(merge_pin),
        .SWITCH_MODE_STRAP(mode_pin), .HALT_BIT_CLEAR(hc), .REG_ACCESS_REQ(rel),
        .CORE_RESET_N(core_reset_n), .SMBUS_ENABLE(smbus_en), .REG_ACCESS_ALLOW(reg_allow),
        .HALT_BIT(halt_bit), .REFCLK_125MHZ(refclk125), .PAIR_MERGED(merged),
        .PORT_ENABLE(port_en), .PORT_LANE_COUNT(lanes_out), .PORT_HIGH_LANES_TO_EVEN(high),
        .EEPROM_INIT(eeprom), .MULTI_PARTITION(multi), .UPSTREAM_PORT(upstream),
        .MODE_RESERVED(reserved));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wait_ready();
        int i;
        i = 0;
        while (halt_bit !== 1'b1 && core_reset_n !== 1'b1) begin
            if (i == 40) begin
                fail_count++;
                complete_run();
            end
            i++;
            tick(1);
        end
    endtask
    task automatic run_row(input srcfg_row_t r);
        logic [31:0] lanes;
        logic [7:0]  odd;
        srcfg_row_t  drv;
        drv = r;
        drv.merge_n = r.merge_n | undriven;
        rel <= 1'b0;
        cur <= drv;
        tick(3);
        check(core_reset_n, 1'b0);
        rel <= 1'b1;
        wait_ready();
        tick(1);
        for (int p = 0; p < 4; p++) begin
            lanes[8*p+:8] = r.merge_n[p] ? 8'h44 : 8'h08;
            odd[2*p+:2] = r.merge_n[p] ? 2'h0 : 2'h2;
        end
        check(refclk125, r.fsel);
        check(merged, 4'(~r.merge_n));
        check(lanes_out, lanes);
        check(high, odd);
        check({eeprom, multi}, {r.eep, r.multi});
        check({upstream, reserved}, {r.up, 1'b0});
        check({port_en[2], port_en[0]}, r.en);
        check({halt_bit, reg_allow, core_reset_n}, r.halt ? 3'h6 : 3'h3);
        check(smbus_en, 1'b1);
    endtask
    task automatic clear_halt();
        tick(12);
        check({halt_bit, core_reset_n}, 2'h2);
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        tick(3);
        check({halt_bit, core_reset_n}, 2'h1);
    endtask
    initial begin
        tick(5);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            run_row(rows[i]);
            if (rows[i].halt) clear_halt();
        end
        // A clear pulse outside the halt state is ignored.
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        tick(3);
        check({halt_bit, core_reset_n}, 2'h1);
        // Merge straps left floating read as merged.
        undriven <= 4'hF;
        tick(1);
        run_row(rows[6]);
        undriven <= 4'h0;
        tick(1);
        // Reset in the middle of a halt restarts the sequence.
        run_row(rows[1]);
        rst_n <= 1'b0;
        tick(2);
        check({halt_bit, smbus_en, reg_allow, core_reset_n}, 4'h0);
        rst_n <= 1'b1;
        tick(1);
        wait_ready();
        clear_halt();
        complete_run();
    end
endmodule
`default_nettype wire
